// File: imcr_buf.sv
`timescale 1ns/1ns
`default_nettype none
module imcr_buf #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    imcr_strm_if.snk in_s,
    imcr_strm_if.src out_s
);
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2) begin : g_bad_depth
        $error("imcr_buf needs DEPTH of at least 2");
    end

    typedef struct packed {
        logic vld;
        logic [CW-1:0] cnt;
        logic [DEPTH-1:0][W-1:0] ent;
    } imcr_buf_st_t;

    imcr_buf_st_t q;
    imcr_buf_st_t n;
    logic pop;
    logic push;

    ////////////////////////////////////////////////////////////////////////////
    // Shift buffer: head is always entry 0, so the output is a plain flop
    always_comb begin
        n = q;
        pop = out_s.ready && (q.cnt != '0);
        push = in_s.valid && (q.cnt != CW'(DEPTH));
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                n.ent[i] = q.ent[i + 1];
            end
            n.cnt = q.cnt - 1'b1;
        end
        if (push) begin
            n.ent[n.cnt] = in_s.data;
            n.cnt = n.cnt + 1'b1;
        end
        // Valid kept as its own flop so the top's output needs no decode
        n.vld = (n.cnt != '0);
    end

    // Register the whole state
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // Full stalls the filler; a pop frees space only on the next cycle
    assign in_s.ready = (q.cnt != CW'(DEPTH));
    assign out_s.valid = q.vld;
    assign out_s.data = q.ent[0];

endmodule
`default_nettype wire

// File: imcr_classify.sv
`timescale 1ns/1ns
`default_nettype none
module imcr_classify import imcr_pkg::*; (
    input wire logic [31:0] src_in,
    input wire logic [31:0] dst_in,
    input wire logic [47:0] ucast_mac_in,
    output var imcr_res_t res_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Scope, role and Ethernet destination from the two addresses
    always_comb begin
        res_out = '0;
        res_out.is_mc = imcr_is_class_d(dst_in);
        res_out.src_bad = imcr_is_class_d(src_in);
        res_out.cls = CLS_UNICAST;
        res_out.role = ROLE_NONE;
        res_out.mac = ucast_mac_in;
        if (res_out.is_mc) begin
            // Only 23 bits survive, so 32 groups alias on one MAC
            res_out.mac = {MAC_OUI, 1'b0, dst_in[22:0]};
            if (dst_in <= RSV_HI) begin
                res_out.cls = CLS_RESERVED;
                // Unlisted octets in the span still report as reserved
                if (dst_in[7:0] <= 8'(ROLE_LAST_LISTED) || dst_in[7:0] == 8'(ROLE_IGMP)) begin
                    res_out.role = dst_in[4:0];
                end else begin
                    res_out.role = ROLE_OTHER;
                end
            end else if (dst_in >= USER_LO && dst_in < LOCAL_LO) begin
                res_out.cls = CLS_USER;
            end else begin
                res_out.cls = CLS_LOCAL;
            end
        end
    end

endmodule
`default_nettype wire

// File: imcr_pkg.sv
// Summary of operation
// - Destination 224.0.0.0 to 239.255.255.255 inclusive is classified multicast.
// - A class D source address marks the packet invalid; it is dropped.
// - 224.0.0.0-224.0.0.255 flagged reserved permanent; 224.0.0.0 marked never assigned.
// - 224.0.1.0 up to the local span is user temporary, network-wide scope.
// - Groups from 239.0.0.0 upward are locally administered, local-domain scope.
// - Well-known reserved groups report a role code, e.g. all-hosts, all-PIM, IGMP.
// - Unicast frames keep the receiver MAC; multicast frames get a derived group MAC.
// - Upper 25 bits of the group MAC are 0x01005e then a zero bit.
// - Lower 23 group address bits copy into the lower 23 MAC bits.
// - Each multicast packet looks up its source in the route table for ingress port.
// - Source tree keys on sender address; shared tree keys on the tree root.
// - Matching ingress port forwards by the forwarding entry; mismatch drops the packet.
// - An accepted packet is copied to every listed outgoing port except its own ingress port.
// - Tunnelled multicast in a unicast header is stripped and handled as multicast.
package imcr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Address spans and group MAC mapping
    localparam logic [31:0] MC_LO = 32'hE000_0000;
    localparam logic [31:0] MC_HI = 32'hEFFF_FFFF;
    localparam logic [31:0] RSV_HI = 32'hE000_00FF;
    localparam logic [31:0] USER_LO = 32'hE000_0100;
    localparam logic [31:0] LOCAL_LO = 32'hEF00_0000;
    localparam logic [23:0] MAC_OUI = 24'h01_005E;
    localparam int PORT_W = 6;
    localparam int BUF_DEPTH = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Role codes: listed groups report their own low octet
    localparam logic [4:0] ROLE_BASE = 5'h00;
    localparam logic [4:0] ROLE_ALL_HOSTS = 5'h01;
    localparam logic [4:0] ROLE_ALL_PIM = 5'h0D;
    localparam logic [4:0] ROLE_LAST_LISTED = 5'h12;
    localparam logic [4:0] ROLE_IGMP = 5'h16;
    localparam logic [4:0] ROLE_NONE = 5'h1E;
    localparam logic [4:0] ROLE_OTHER = 5'h1F;

    typedef enum logic [1:0] {
        CLS_UNICAST = 2'h0,
        CLS_RESERVED = 2'h1,
        CLS_USER = 2'h2,
        CLS_LOCAL = 2'h3
    } imcr_cls_t;

    typedef struct packed {
        logic is_mc;
        logic src_bad;
        imcr_cls_t cls;
        logic [4:0] role;
        logic [47:0] mac;
    } imcr_res_t;

    typedef struct packed {
        logic decap;
        imcr_res_t res;
        logic fwd;
        logic last;
        logic [PORT_W-1:0] port;
    } imcr_verdict_t;

    localparam int VERDICT_W = $bits(imcr_verdict_t);

    // Class D test, shared by source and destination checks
    function automatic logic imcr_is_class_d(input logic [31:0] a);
        return (a >= MC_LO) && (a <= MC_HI);
    endfunction

endpackage

// File: imcr_route_model.sv
`timescale 1ns/1ns
`default_nettype none
module imcr_route_model import imcr_pkg::*; #(
    parameter int NPORT = 8
) (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic req_in,
    input wire logic [31:0] key_in,
    input wire logic [3:0] delay_in,
    output logic ack_out,
    output logic hit_out,
    output logic [PORT_W-1:0] port_out,
    output logic [NPORT-1:0] oif_out
);
    logic [3:0] wait_q;

    ////////////////////////////////////////////////////////////////////////////
    // Route table stand-in; answer fields toggle whenever no answer is given,
    // so a design that samples them outside the ack cycle sees junk
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            wait_q <= 4'h0;
            ack_out <= 1'b0;
            hit_out <= 1'b0;
            port_out <= '0;
            oif_out <= '0;
        end else begin
            ack_out <= 1'b0;
            hit_out <= ~hit_out;
            port_out <= ~port_out;
            oif_out <= ~oif_out;
            wait_q <= 4'h0;
            if (req_in && !ack_out && wait_q != delay_in) begin
                wait_q <= wait_q + 4'h1; // Slow answer: delay_in idle cycles
            end
            if (req_in && !ack_out && wait_q == delay_in) begin
                ack_out <= 1'b1; // One-cycle answer while the request stands
                hit_out <= 1'b1;
                case (key_in)
                    32'h0A00_0001: begin
                        port_out <= 6'h02;
                        oif_out <= NPORT'(8'h26);
                    end
                    32'h0A00_0009: begin
                        port_out <= 6'h04;
                        oif_out <= NPORT'(8'h81);
                    end
                    default: begin
                        hit_out <= 1'b0; // Unknown key: no route
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: imcr_strm_if.sv
`timescale 1ns/1ns
`default_nettype none
interface imcr_strm_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// File: imcr_top.sv
`timescale 1ns/1ns
`default_nettype none
module imcr_top import imcr_pkg::*; #(
    parameter int NPORT = 8
) (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic hdr_valid_in,
    output logic hdr_ready_out,
    input wire logic [31:0] hdr_src_in,
    input wire logic [31:0] hdr_dst_in,
    input wire logic hdr_tunnel_in,
    input wire logic [31:0] hdr_inner_src_in,
    input wire logic [31:0] hdr_inner_dst_in,
    input wire logic hdr_shared_in,
    input wire logic [31:0] hdr_root_in,
    input wire logic [PORT_W-1:0] hdr_ing_port_in,
    input wire logic [47:0] hdr_dst_mac_in,
    output logic lkp_req_out,
    output logic [31:0] lkp_key_out,
    output logic [31:0] lkp_grp_out,
    input wire logic lkp_ack_in,
    input wire logic lkp_hit_in,
    input wire logic [PORT_W-1:0] lkp_port_in,
    input wire logic [NPORT-1:0] lkp_oif_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [PORT_W-1:0] out_port_out,
    output logic [47:0] out_mac_out,
    output logic out_fwd_out,
    output logic out_last_out,
    output logic [1:0] out_cls_out,
    output logic [4:0] out_role_out,
    output logic out_src_bad_out,
    output logic out_decap_out
);

    if (NPORT < 2 || NPORT > (1 << PORT_W)) begin : g_bad_nport
        $error("imcr_top NPORT must lie between 2 and 2**PORT_W");
    end

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CLASS = 4'b0010,
        ST_LOOKUP = 4'b0100,
        ST_EMIT = 4'b1000
    } imcr_st_t;

    typedef struct packed {
        imcr_st_t st;
        logic rdy;
        logic [31:0] src;
        logic [31:0] dst;
        logic [31:0] root;
        logic shared;
        logic decap;
        logic [PORT_W-1:0] ing;
        logic [47:0] ucmac;
        logic req;
        logic [31:0] key;
        logic fwd;
        logic [NPORT-1:0] mask;
    } imcr_top_st_t;

    localparam imcr_top_st_t RST_ST = '{st: ST_IDLE, rdy: 1'b1, default: '0};

    imcr_top_st_t q;
    imcr_top_st_t n;
    imcr_res_t cls;
    imcr_verdict_t vd;
    logic [NPORT-1:0] ingbit;
    logic [NPORT-1:0] one;
    logic [NPORT-1:0] oif;
    logic rpf_ok;
    logic strip;
    logic push;

    imcr_strm_if #(.W(VERDICT_W)) bin ();
    imcr_strm_if #(.W(VERDICT_W)) bout ();

    // Index of the lowest set port bit
    function automatic logic [PORT_W-1:0] lsb_idx(input logic [NPORT-1:0] m);
        logic [PORT_W-1:0] r;
        r = '0;
        for (int i = NPORT - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = PORT_W'(i);
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Address classification on the captured header
    imcr_classify u_cls (
        .src_in(q.src),
        .dst_in(q.dst),
        .ucast_mac_in(q.ucmac),
        .res_out(cls)
    );

    // Ingress bit; an out-of-range port shifts out to zero
    assign ingbit = {{(NPORT - 1){1'b0}}, 1'b1} << q.ing;
    assign one = q.mask & (~q.mask + 1'b1);
    assign oif = lkp_oif_in & ~ingbit;
    assign rpf_ok = lkp_hit_in && (lkp_port_in == q.ing);
    // Only a unicast outer header is stripped; a multicast outer is the packet
    assign strip = hdr_tunnel_in && !imcr_is_class_d(hdr_dst_in);

    ////////////////////////////////////////////////////////////////////////////
    // Header sequencer: one header in flight keeps verdicts in arrival order
    always_comb begin
        n = q;
        push = 1'b0;
        vd = '0;
        unique case (q.st)
            ST_IDLE: begin
                if (hdr_valid_in && q.rdy) begin
                    n.rdy = 1'b0;
                    n.decap = strip;
                    n.src = strip ? hdr_inner_src_in : hdr_src_in;
                    n.dst = strip ? hdr_inner_dst_in : hdr_dst_in;
                    n.root = hdr_root_in;
                    n.shared = hdr_shared_in;
                    n.ing = hdr_ing_port_in;
                    n.ucmac = hdr_dst_mac_in;
                    n.st = ST_CLASS;
                end
            end
            ST_CLASS: begin
                if (cls.is_mc && !cls.src_bad) begin
                    n.req = 1'b1;
                    n.key = q.shared ? q.root : q.src;
                    n.st = ST_LOOKUP;
                end else begin
                    // Unicast passes once; a bad source is dropped
                    n.fwd = !cls.is_mc && !cls.src_bad;
                    n.mask = '0;
                    n.st = ST_EMIT;
                end
            end
            ST_LOOKUP: begin
                if (lkp_ack_in) begin
                    n.req = 1'b0;
                    n.fwd = rpf_ok && (oif != '0);
                    n.mask = rpf_ok ? oif : '0;
                    n.st = ST_EMIT;
                end
            end
            ST_EMIT: begin
                push = 1'b1;
                vd.decap = q.decap;
                vd.res = cls;
                vd.fwd = q.fwd;
                vd.last = (q.mask == one);
                vd.port = lsb_idx(q.mask);
                if (bin.ready) begin
                    n.mask = q.mask & ~one;
                    if (vd.last) begin
                        n.fwd = 1'b0;
                        n.rdy = 1'b1;
                        n.st = ST_IDLE;
                    end
                end
            end
            default: begin
                n = RST_ST;
            end
        endcase
    end

    // State register; reset drops every pending request and verdict
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            q <= RST_ST;
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Verdict buffer: a stalled receiver back-pressures the sequencer
    assign bin.valid = push;
    assign bin.data = vd;
    assign bout.ready = out_ready_in;

    imcr_buf #(.W(VERDICT_W), .DEPTH(BUF_DEPTH)) u_buf (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .in_s(bin),
        .out_s(bout)
    );

    // Outputs straight from flops
    imcr_verdict_t ov;
    assign ov = bout.data;
    assign hdr_ready_out = q.rdy;
    assign lkp_req_out = q.req;
    assign lkp_key_out = q.key;
    assign lkp_grp_out = q.dst;
    assign out_valid_out = bout.valid;
    assign out_port_out = ov.port;
    assign out_mac_out = ov.res.mac;
    assign out_fwd_out = ov.fwd;
    assign out_last_out = ov.last;
    assign out_cls_out = ov.res.cls;
    assign out_role_out = ov.res.role;
    assign out_src_bad_out = ov.res.src_bad;
    assign out_decap_out = ov.decap;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    mc_range_a: assert property (q.st == ST_CLASS |-> cls.is_mc == (q.dst >= MC_LO && q.dst <= MC_HI))
        else $error("class D decode wrong");
    src_drop_a: assert property ((q.st == ST_CLASS && cls.src_bad) |=> (q.st == ST_EMIT && !q.fwd))
        else $error("class D source not dropped");
    rsv_scope_a: assert property ((q.st == ST_CLASS && cls.is_mc && q.dst <= RSV_HI)
        |-> (cls.cls == CLS_RESERVED && (q.dst != MC_LO || cls.role == ROLE_BASE)))
        else $error("reserved span misclassified");
    user_scope_a: assert property ((q.st == ST_CLASS && q.dst >= USER_LO && q.dst < LOCAL_LO)
        |-> cls.cls == CLS_USER)
        else $error("user span misclassified");
    local_scope_a: assert property ((q.st == ST_CLASS && q.dst >= LOCAL_LO && q.dst <= MC_HI)
        |-> cls.cls == CLS_LOCAL)
        else $error("local span misclassified");
    role_code_a: assert property ((q.st == ST_CLASS && q.dst == (MC_LO | 32'(ROLE_IGMP)))
        |-> cls.role == ROLE_IGMP)
        else $error("well-known role wrong");
    ucast_mac_a: assert property ((push && !vd.res.is_mc) |-> vd.res.mac == q.ucmac)
        else $error("unicast MAC altered");
    mac_map_a: assert property ((push && vd.res.is_mc) |-> vd.res.mac == {MAC_OUI, 1'b0, q.dst[22:0]})
        else $error("group MAC mapping wrong");
    key_sel_a: assert property ($rose(lkp_req_out) |-> lkp_key_out == (q.shared ? q.root : q.src))
        else $error("lookup key wrong");
    rpf_drop_a: assert property ((q.st == ST_LOOKUP && lkp_ack_in && !rpf_ok)
        |=> (q.st == ST_EMIT && !q.fwd && q.mask == '0))
        else $error("reverse path mismatch not dropped");
    copy_set_a: assert property ((q.st == ST_LOOKUP && lkp_ack_in && rpf_ok)
        |=> q.mask == ($past(lkp_oif_in) & ~ingbit))
        else $error("copy port set wrong");
    tunnel_strip_a: assert property ((q.st == ST_IDLE && hdr_valid_in && q.rdy && strip)
        |=> (q.decap && q.dst == $past(hdr_inner_dst_in)))
        else $error("tunnel header not stripped");
    one_flight_a: assert property ((q.st == ST_IDLE && hdr_valid_in && q.rdy) |=> (!hdr_ready_out)[*2])
        else $error("second header taken in flight");
    rst_clear_a: assert property (@(posedge clk_sys_in) disable iff (1'b0)
        srst_in |=> (!out_valid_out && !lkp_req_out && hdr_ready_out))
        else $error("reset left a valid flag");

endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top import imcr_pkg::*; ;
    localparam logic [47:0] STN_MAC = 48'h02AB_CD00_0001;
    logic clk_sys_in, srst_in, hdr_valid_in, hdr_tunnel_in, hdr_shared_in, out_ready_in;
    logic hdr_ready_out, lkp_req_out, lkp_ack_in, lkp_hit_in, out_valid_out, out_fwd_out, out_last_out;
    logic out_src_bad_out, out_decap_out;
    logic [31:0] hdr_src_in, hdr_dst_in, hdr_inner_src_in, hdr_inner_dst_in, hdr_root_in, lkp_key_out;
    logic [31:0] lkp_grp_out, seen_key, seen_grp;
    logic [PORT_W-1:0] hdr_ing_port_in, lkp_port_in, out_port_out;
    logic [47:0] hdr_dst_mac_in, out_mac_out;
    logic [7:0] lkp_oif_in;
    logic [1:0] out_cls_out;
    logic [4:0] out_role_out;
    logic [3:0] dly;
    logic [7:0] lkp_cnt = 8'h00;
    logic [64:0] exp_q[$];
    logic [64:0] got_q[$];
    logic [31:0] grp_list [12] = '{32'hE000_0000, 32'hE000_0001, 32'hE000_000D, 32'hE000_0012, 32'hE000_0013,
        32'hE000_0016, 32'hE000_0017, 32'hE000_00FF, 32'hE000_0100, 32'hEEFF_FFFF, 32'hEF00_0000, 32'hEFFF_FFFF};
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;

    imcr_top #(.NPORT(8)) dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .hdr_valid_in(hdr_valid_in),
        .hdr_ready_out(hdr_ready_out), .hdr_src_in(hdr_src_in), .hdr_dst_in(hdr_dst_in),
        .hdr_tunnel_in(hdr_tunnel_in), .hdr_inner_src_in(hdr_inner_src_in), .hdr_inner_dst_in(hdr_inner_dst_in),
        .hdr_shared_in(hdr_shared_in), .hdr_root_in(hdr_root_in), .hdr_ing_port_in(hdr_ing_port_in),
        .hdr_dst_mac_in(hdr_dst_mac_in), .lkp_req_out(lkp_req_out), .lkp_key_out(lkp_key_out),
        .lkp_grp_out(lkp_grp_out), .lkp_ack_in(lkp_ack_in), .lkp_hit_in(lkp_hit_in), .lkp_port_in(lkp_port_in),
        .lkp_oif_in(lkp_oif_in), .out_valid_out(out_valid_out), .out_ready_in(out_ready_in),
        .out_port_out(out_port_out), .out_mac_out(out_mac_out), .out_fwd_out(out_fwd_out),
        .out_last_out(out_last_out), .out_cls_out(out_cls_out), .out_role_out(out_role_out),
        .out_src_bad_out(out_src_bad_out), .out_decap_out(out_decap_out));
    imcr_route_model #(.NPORT(8)) route (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .req_in(lkp_req_out),
        .key_in(lkp_key_out), .delay_in(dly), .ack_out(lkp_ack_in), .hit_out(lkp_hit_in),
        .port_out(lkp_port_in), .oif_out(lkp_oif_in));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, hang guard and lookup monitor
    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            miscompares++; // A hang counts as a mismatch
            print_verdict();
        end
    end
    always @(posedge clk_sys_in) begin
        if (lkp_req_out === 1'b1 && lkp_ack_in === 1'b1) begin
            seen_key <= lkp_key_out;
            seen_grp <= lkp_grp_out;
            lkp_cnt <= lkp_cnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compares, expectation helpers and the header driver
    task automatic chk_word(input logic [64:0] got, input logic [64:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [64:0] mk(input logic [5:0] p, input logic [47:0] m, input logic f, input logic l,
        input imcr_cls_t c, input logic [4:0] r, input logic b, input logic dc);
        return {p, m, f, l, c, r, b, dc};
    endfunction
    function automatic logic [47:0] gmac(input logic [31:0] d);
        return {24'h01_005E, 1'b0, d[22:0]};
    endfunction
    function automatic imcr_cls_t exp_cls(input logic [31:0] d);
        return (d[31:8] == 24'hE0_0000) ? CLS_RESERVED : ((d[31:24] == 8'hEF) ? CLS_LOCAL : CLS_USER);
    endfunction
    function automatic logic [4:0] exp_role(input logic [31:0] d);
        if (d[31:8] != 24'hE0_0000) begin
            return ROLE_NONE;
        end
        return (d[7:0] <= 8'h12 || d[7:0] == 8'h16) ? d[4:0] : ROLE_OTHER;
    endfunction
    // Offer one header, hold it until taken, then gather its words; optional receiver stall
    task automatic run_hdr(input logic [31:0] s, input logic [31:0] d, input logic [31:0] rt, input logic sh,
        input logic [5:0] ing, input logic stall);
        got_q.delete();
        @(negedge clk_sys_in);
        hdr_valid_in = 1'b1;
        hdr_src_in = s;
        hdr_dst_in = d;
        hdr_root_in = rt;
        hdr_shared_in = sh;
        hdr_ing_port_in = ing;
        // Ready is judged between edges; the next rising edge takes the header
        while (hdr_ready_out !== 1'b1) @(negedge clk_sys_in);
        @(negedge clk_sys_in);
        hdr_valid_in = 1'b0;
        for (int n = 0; n < 300; n++) begin
            @(negedge clk_sys_in);
            out_ready_in = !(stall && n[0]);
            if (out_valid_out === 1'b1 && out_ready_in) begin
                got_q.push_back({out_port_out, out_mac_out, out_fwd_out, out_last_out, out_cls_out,
                    out_role_out, out_src_bad_out, out_decap_out});
                if (out_last_out === 1'b1) break;
            end
        end
        chk_val(got_q.size(), exp_q.size());
        foreach (exp_q[i]) if (i < got_q.size()) chk_word(got_q[i], exp_q[i]);
        exp_q.delete();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_unicast;
        exp_q.push_back(mk(6'h00, STN_MAC, 1'b1, 1'b1, CLS_UNICAST, ROLE_NONE, 1'b0, 1'b0));
        run_hdr(32'h0A00_0001, 32'hDFFF_FFFF, 32'h0, 1'b0, 6'h01, 1'b0);
        hdr_dst_mac_in = 48'h02AB_CD00_0077;
        exp_q.push_back(mk(6'h00, 48'h02AB_CD00_0077, 1'b1, 1'b1, CLS_UNICAST, ROLE_NONE, 1'b0, 1'b0));
        run_hdr(32'h0A00_0001, 32'hF000_0000, 32'h0, 1'b0, 6'h01, 1'b0);
        hdr_dst_mac_in = STN_MAC;
        $display("test unicast done");
    endtask
    // Class D sources at both span edges: every group gives one drop word and no lookup
    task automatic t_groups;
        logic [7:0] base;
        base = lkp_cnt;
        foreach (grp_list[i]) begin
            exp_q.push_back(mk(6'h00, gmac(grp_list[i]), 1'b0, 1'b1, exp_cls(grp_list[i]),
                exp_role(grp_list[i]), 1'b1, 1'b0));
            run_hdr(i[0] ? 32'hEFFF_FFFF : 32'hE000_0000, grp_list[i], 32'h0, 1'b0, 6'h01, 1'b0);
        end
        chk_val(lkp_cnt, base);
        $display("test groups done");
    endtask
    task automatic t_rpf;
        dly = 4'h0;
        exp_q.push_back(mk(6'h01, gmac(32'hEF80_1234), 1'b1, 1'b0, CLS_LOCAL, ROLE_NONE, 1'b0, 1'b0));
        exp_q.push_back(mk(6'h05, gmac(32'hEF80_1234), 1'b1, 1'b1, CLS_LOCAL, ROLE_NONE, 1'b0, 1'b0));
        run_hdr(32'h0A00_0001, 32'hEF80_1234, 32'h0A00_0009, 1'b0, 6'h02, 1'b1);
        chk_val(seen_key, 32'h0A00_0001);
        chk_val(seen_grp, 32'hEF80_1234);
        dly = 4'h9;
        exp_q.push_back(mk(6'h00, gmac(32'hEF80_1234), 1'b0, 1'b1, CLS_LOCAL, ROLE_NONE, 1'b0, 1'b0));
        run_hdr(32'h0A00_0001, 32'hEF80_1234, 32'h0A00_0009, 1'b0, 6'h03, 1'b0);
        $display("test reverse path done");
    endtask
    task automatic t_shared;
        dly = 4'h3;
        exp_q.push_back(mk(6'h00, gmac(32'hE000_0116), 1'b1, 1'b0, CLS_USER, ROLE_NONE, 1'b0, 1'b0));
        exp_q.push_back(mk(6'h07, gmac(32'hE000_0116), 1'b1, 1'b1, CLS_USER, ROLE_NONE, 1'b0, 1'b0));
        run_hdr(32'h0A00_0077, 32'hE000_0116, 32'h0A00_0009, 1'b1, 6'h04, 1'b1);
        chk_val(seen_key, 32'h0A00_0009);
        $display("test shared tree done");
    endtask
    task automatic t_tunnel;
        hdr_tunnel_in = 1'b1;
        hdr_inner_src_in = 32'h0A00_0001;
        hdr_inner_dst_in = 32'hE000_0001;
        exp_q.push_back(mk(6'h01, gmac(32'hE000_0001), 1'b1, 1'b0, CLS_RESERVED, 5'h01, 1'b0, 1'b1));
        exp_q.push_back(mk(6'h05, gmac(32'hE000_0001), 1'b1, 1'b1, CLS_RESERVED, 5'h01, 1'b0, 1'b1));
        run_hdr(32'h0A00_00FE, 32'h0A00_00FD, 32'h0, 1'b0, 6'h02, 1'b0);
        chk_val(seen_key, 32'h0A00_0001);
        chk_val(seen_grp, 32'hE000_0001);
        hdr_tunnel_in = 1'b0;
        $display("test tunnel done");
    endtask
    // Reset while a slow lookup is pending; the lost header must leave no word behind
    task automatic t_reset;
        dly = 4'hF;
        @(negedge clk_sys_in);
        hdr_valid_in = 1'b1;
        hdr_src_in = 32'h0A00_0001;
        hdr_dst_in = 32'hEF80_1234;
        hdr_ing_port_in = 6'h02;
        @(negedge clk_sys_in);
        hdr_valid_in = 1'b0;
        repeat (4) @(negedge clk_sys_in);
        srst_in = 1'b1;
        @(negedge clk_sys_in);
        chk_val({out_valid_out, lkp_req_out, hdr_ready_out}, 32'h1);
        srst_in = 1'b0;
        dly = 4'h0;
        exp_q.push_back(mk(6'h00, STN_MAC, 1'b1, 1'b1, CLS_UNICAST, ROLE_NONE, 1'b0, 1'b0));
        run_hdr(32'h0A00_0001, 32'h0A00_0002, 32'h0, 1'b0, 6'h01, 1'b0);
        $display("test reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and main sequence
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        srst_in = 1'b1;
        {hdr_valid_in, hdr_tunnel_in, hdr_shared_in} = 3'h0;
        {hdr_src_in, hdr_dst_in, hdr_inner_src_in, hdr_inner_dst_in, hdr_root_in} = '0;
        hdr_ing_port_in = 6'h00;
        hdr_dst_mac_in = STN_MAC;
        out_ready_in = 1'b1;
        dly = 4'h0;
        repeat (5) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        srst_in = 1'b0;
        t_unicast();
        t_groups();
        t_rpf();
        t_shared();
        t_tunnel();
        t_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
